// ==== logic/clk_out_park.sv ====
// Park, stop and restart control for the differential clock output pairs.
// Assumes the reference clock is far slower than the 125 MHz system clock.
//
// Summary of operation
// - Read-length register, eight bits, read/write, resets to 0x07.
// - Power-down pin is asynchronous, active low, controls entry and exit.
// - Outputs park first; the PLL is shut down only afterwards.
// - Power-down taken after two low samples; park at next complement fall.
// - Power-down park select zero: true driven high, complement undriven.
// - Power-down park select one: both outputs of every pair undriven.
// - Locked stable clocks within 1 ms of power-down release.
// - With park select one, outputs driven high well within 300 us.
// - Halt pin is asynchronous, active low, needs a running reference clock.
// - Halt assertion or release accepted after two stable samples.
// - Stoppable outputs halt after their next transition; others keep running.
// - Stop park select zero: true high, complement undriven.
// - Stop park select one: both outputs undriven.
// - Release restarts all stopped outputs together, glitch free, 2 to 6 periods.
// - With stop park select one, stopped outputs driven high promptly on release.
// - An output runs only with its enable bit set and enable pin active.
// - Per-output stoppable bit, zero free-running, resets to free-running.
`timescale 1ns/10ps
module clk_out_park
  import clk_park_pkg::*;
#(
  parameter int N_OUT       = NUM_OUTPUTS,
  parameter int LOCK_CYC    = LOCK_CYCLES
) (
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  input  wire logic             input_ref_clock_i,
  input  wire logic             power_down_n_i,
  input  wire logic             output_halt_n_i,
  input  wire logic [N_OUT-1:0] oe_pin_i,
  input  wire logic             enable_polarity_sel_i,
  input  wire logic [N_OUT-1:0] out_enable_i,
  input  wire logic [N_OUT-1:0] stoppable_i,
  input  wire logic             powerdown_park_sel_i,
  input  wire logic             stop_park_sel_i,
  input  wire logic             reg_wr_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [7:0]       reg_wdata_i,
  output logic [7:0]            reg_rdata_o,
  output logic [7:0]            read_len_o,
  output logic [N_OUT-1:0]      clk_out_true_o,
  output logic [N_OUT-1:0]      clk_out_true_oe_o,
  output logic [N_OUT-1:0]      clk_out_comp_o,
  output logic [N_OUT-1:0]      clk_out_comp_oe_o,
  output logic                  drive_2x_o,
  output logic                  pll_enable_o,
  output logic                  pll_locked_o
);

  localparam int CW = $clog2(LOCK_CYC + 1);

  if (N_OUT < 1 || LOCK_CYC < 1) begin : g_bad_param
    $error("clk_out_park: N_OUT and LOCK_CYC must be at least one");
  end

  // ==========================================================================
  // Management register
  // ==========================================================================
  logic [7:0] read_len_q;
  logic [7:0] rdata_q;
  wire        len_hit = (reg_addr_i == REG_ADDR_READ_LEN);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      read_len_q <= READ_LEN_RESET;
      rdata_q    <= REG_READ_ZERO;
    end else begin
      if (reg_wr_i && len_hit) begin
        read_len_q <= reg_wdata_i;
      end
      rdata_q <= len_hit ? read_len_q : REG_READ_ZERO;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign read_len_o  = read_len_q;

  // ==========================================================================
  // Reference clock recovery
  // ==========================================================================
  // The reference is oversampled; the output phase follows it three cycles late.
  logic ref_meta_q;
  logic ref_sync_q;
  logic ref_prev_q;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ref_meta_q <= 1'b0;
      ref_sync_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end else begin
      ref_meta_q <= input_ref_clock_i;
      ref_sync_q <= ref_meta_q;
      ref_prev_q <= ref_sync_q;
    end
  end

  // Complement rises when the true phase falls and vice versa.
  wire comp_rise = ref_prev_q & ~ref_sync_q;
  wire comp_fall = ~ref_prev_q & ref_sync_q;

  // ==========================================================================
  // Pin debouncing
  // ==========================================================================
  logic pd_n_deb;
  logic halt_n_deb;
  logic halt_n_sync;

  pin_debounce #(.RESET_LEVEL(1'b1)) u_pd_deb (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (power_down_n_i),
    .sample_i  (comp_rise),
    .synced_o  (),
    .level_o   (pd_n_deb)
  );

  pin_debounce #(.RESET_LEVEL(1'b1)) u_halt_deb (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (output_halt_n_i),
    .sample_i  (comp_rise),
    .synced_o  (halt_n_sync),
    .level_o   (halt_n_deb)
  );

  logic [N_OUT-1:0] oe_meta_q;
  logic [N_OUT-1:0] oe_sync_q;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      oe_meta_q <= '0;
      oe_sync_q <= '0;
    end else begin
      oe_meta_q <= oe_pin_i;
      oe_sync_q <= oe_meta_q;
    end
  end

  // ==========================================================================
  // Power-down sequencing
  // ==========================================================================
  pd_state_t state_q;
  pd_state_t state_d;
  logic [CW-1:0] lock_cnt_q;
  logic          pd_sel_q;
  logic          pll_en_q;
  wire           lock_done = (lock_cnt_q == CW'(LOCK_CYC - 1));

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (!pd_n_deb && comp_fall) begin
          state_d = ST_PD_PARK;
        end
      end
      ST_PD_PARK: begin
        if (pd_n_deb) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (!pd_n_deb) begin
          state_d = ST_PD_PARK;
        end else if (lock_done) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_WAKE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_q    <= ST_WAKE;
      lock_cnt_q <= '0;
      pd_sel_q   <= 1'b0;
    end else begin
      state_q    <= state_d;
      lock_cnt_q <= (state_q == ST_WAKE && !lock_done) ? lock_cnt_q + 1'b1 : '0;
      if (state_q == ST_RUN && state_d == ST_PD_PARK) begin
        pd_sel_q <= powerdown_park_sel_i;
      end
    end
  end

  assign pll_enable_o = pll_en_q;
  assign pll_locked_o = (state_q == ST_RUN);

  // ==========================================================================
  // Per-output stop and drive
  // ==========================================================================
  logic [N_OUT-1:0] stopped_q;
  logic             stop_sel_q;
  logic [N_OUT-1:0] true_q;
  logic [N_OUT-1:0] true_oe_q;
  logic [N_OUT-1:0] comp_q;
  logic [N_OUT-1:0] comp_oe_q;
  logic             drive_2x_q;
  wire  [N_OUT-1:0] pin_active = oe_sync_q ^ {N_OUT{enable_polarity_sel_i}};
  wire  [N_OUT-1:0] enabled    = out_enable_i & pin_active;
  wire              in_pd      = (state_q == ST_PD_PARK);
  wire              in_wake    = (state_q == ST_WAKE);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      stop_sel_q <= 1'b0;
    end else if (!halt_n_deb && comp_fall && ((stoppable_i & ~stopped_q) != '0)) begin
      stop_sel_q <= stop_park_sel_i;
    end
  end

  for (genvar g = 0; g < N_OUT; g++) begin : g_lane
    logic stop_d;
    logic t_d;
    logic toe_d;
    logic c_d;
    logic coe_d;

    always_comb begin
      stop_d = stopped_q[g];
      if (!halt_n_deb && stoppable_i[g] && comp_fall) begin
        stop_d = 1'b1;
      end else if (halt_n_deb && comp_rise) begin
        stop_d = 1'b0;
      end
      t_d   = ref_sync_q;
      toe_d = 1'b1;
      c_d   = ~ref_sync_q;
      coe_d = 1'b1;
      if (in_pd) begin
        t_d   = 1'b1;
        toe_d = ~pd_sel_q;
        c_d   = 1'b0;
        coe_d = 1'b0;
      end else if (in_wake) begin
        t_d   = 1'b1;
        c_d   = 1'b0;
        coe_d = 1'b0;
      end else if (!enabled[g]) begin
        t_d   = 1'b0;
        toe_d = 1'b0;
        c_d   = 1'b0;
        coe_d = 1'b0;
      end else if (stopped_q[g]) begin
        t_d   = 1'b1;
        // A synced release drives high before the debouncer has settled.
        toe_d = ~stop_sel_q | halt_n_sync;
        c_d   = 1'b0;
        coe_d = 1'b0;
      end
    end

    always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
        stopped_q[g] <= 1'b0;
        true_q[g]    <= 1'b0;
        true_oe_q[g] <= 1'b0;
        comp_q[g]    <= 1'b0;
        comp_oe_q[g] <= 1'b0;
      end else begin
        stopped_q[g] <= stop_d;
        true_q[g]    <= t_d;
        true_oe_q[g] <= toe_d;
        comp_q[g]    <= c_d;
        comp_oe_q[g] <= coe_d;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      drive_2x_q <= 1'b0;
      pll_en_q   <= 1'b1;
    end else begin
      drive_2x_q <= in_pd;
      // The PLL stops only once the outputs have sat parked for a cycle.
      pll_en_q   <= !(in_pd && drive_2x_q);
    end
  end

  assign clk_out_true_o    = true_q;
  assign clk_out_true_oe_o = true_oe_q;
  assign clk_out_comp_o    = comp_q;
  assign clk_out_comp_oe_o = comp_oe_q;
  assign drive_2x_o        = drive_2x_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  AST_LEN_WRITE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_wr_i && len_hit |=> read_len_q == $past(reg_wdata_i))
    else $error("read length not updated by write");
  AST_PD_ENTRY: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state_q == ST_RUN && !pd_n_deb && comp_fall |=> state_q == ST_PD_PARK)
    else $error("power-down park missed");
  AST_PLL_ORDER: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(pll_en_q) |-> $past(state_q == ST_PD_PARK) && !true_oe_q[0] == pd_sel_q)
    else $error("PLL stopped before outputs parked");
  AST_PD_DRIVEN: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    in_pd && !pd_sel_q |=> true_q == '1 && true_oe_q == '1 && comp_oe_q == '0)
    else $error("driven power-down park wrong");
  AST_PD_HIZ: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    in_pd && pd_sel_q |=> true_oe_q == '0 && comp_oe_q == '0)
    else $error("tri-state power-down park wrong");
  AST_LOCK_BOUND: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    in_wake && pd_n_deb && lock_done |=> state_q == ST_RUN && pll_locked_o)
    else $error("lock not reached in time");
  AST_STOP_DRIVEN: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state_q == ST_RUN && stopped_q[0] && enabled[0] && !stop_sel_q
      |=> true_q[0] && true_oe_q[0] && !comp_oe_q[0])
    else $error("driven stop park wrong");
  AST_STOP_HIZ: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state_q == ST_RUN && stopped_q[0] && enabled[0] && stop_sel_q && !halt_n_sync
      |=> !true_oe_q[0] && !comp_oe_q[0])
    else $error("tri-state stop park wrong");
  AST_FREE_RUN: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (stopped_q & ~$past(stopped_q) & ~$past(stoppable_i)) == '0)
    else $error("free-running output stopped");
  AST_STOP_RELEASE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state_q == ST_RUN && stopped_q[0] && enabled[0] && halt_n_sync |=> true_oe_q[0])
    else $error("stopped output not driven on release");

endmodule : clk_out_park

// ==== logic/clk_park_pkg.sv ====
// Constants shared by the clock output park and stop logic.
// Assumes a 125 MHz system clock that also oversamples the reference clock.
package clk_park_pkg;

  // ==========================================================================
  // Management register map
  // ==========================================================================
  localparam logic [7:0] REG_ADDR_READ_LEN = 8'h06;
  localparam logic [7:0] READ_LEN_RESET    = 8'h07;
  localparam logic [7:0] REG_READ_ZERO     = 8'h00;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 8;
  localparam int LOCK_TIME_NS  = 1000000;
  // A longest time rounds down to whole cycles.
  localparam int LOCK_CYCLES   = LOCK_TIME_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Structure
  // ==========================================================================
  localparam int NUM_OUTPUTS = 4;

  typedef enum logic [1:0] {
    ST_RUN     = 2'h0,
    ST_PD_PARK = 2'h1,
    ST_WAKE    = 2'h3
  } pd_state_t;

endpackage : clk_park_pkg

// ==== logic/pin_debounce.sv ====
// Synchroniser and two-sample debouncer for an asynchronous control pin.
// Assumes sample_i is a one-cycle pulse on the system clock.
`timescale 1ns/10ps
module pin_debounce #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic pin_i,
  input  wire logic sample_i,
  output logic      synced_o,
  output logic      level_o
);

  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic level_q;

  // ==========================================================================
  // Two-flop synchroniser, then acceptance after two equal samples
  // ==========================================================================
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      meta_q  <= RESET_LEVEL;
      sync_q  <= RESET_LEVEL;
      prev_q  <= RESET_LEVEL;
      level_q <= RESET_LEVEL;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      if (sample_i) begin
        prev_q <= sync_q;
        if (prev_q == sync_q) begin
          level_q <= sync_q;
        end
      end
    end
  end

  assign synced_o = sync_q;
  assign level_o  = level_q;

endmodule : pin_debounce

// ==== testbench/pm_partner.sv ====
// Behavioural platform power manager: makes the reference clock, drives the stop pins.
// Assumes the bench changes its requests just after a rising system clock edge.
`timescale 1ns/10ps
module pm_partner #(
  parameter int REF_HALF = 8
) (
  input  wire logic clk_sys_i,
  input  wire logic pd_req_i,
  input  wire logic halt_req_i,
  input  wire logic ref_off_req_i,
  output logic      input_ref_clock_o,
  output logic      power_down_n_o,
  output logic      output_halt_n_o
);
  int   half_cnt;
  logic ref_run;

  // ====================================================================
  // Pin drive
  // ====================================================================
  // The clock may only be taken away once power-down already sits low.
  assign ref_run = !(ref_off_req_i && !power_down_n_o);

  initial begin
    input_ref_clock_o = 1'b0;
    power_down_n_o = 1'b1;
    output_halt_n_o = 1'b1;
    half_cnt = 0;
  end

  always @(posedge clk_sys_i) begin
    power_down_n_o <= !pd_req_i;
    output_halt_n_o <= !halt_req_i;
    if (ref_run) begin
      half_cnt <= (half_cnt == REF_HALF - 1) ? 0 : half_cnt + 1;
      if (half_cnt == REF_HALF - 1) begin
        input_ref_clock_o <= !input_ref_clock_o;
      end
    end
  end
endmodule : pm_partner

// ==== testbench/clk_out_park_tb.sv ====
// Self-checking bench for the clock output park and stop control.
// Assumes the lock wait is shortened to LK cycles and a reference 16 cycles long.
`timescale 1ns/10ps
module clk_out_park_tb import clk_park_pkg::*;;
  localparam int LK = 20;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       ref_clk, pd_n, halt_n;
  logic       pd_r = 1'b0, h_r = 1'b0, off_r = 1'b0;
  logic [3:0] oe_pin = 4'hF, oen = 4'h7, stp = 4'h5;
  logic       pol = 1'b0, pd_sel = 1'b0, st_sel = 1'b0, wr = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rd, rl;
  logic [3:0] t_o, t_oe, c_o, c_oe;
  logic       x2, pe, pl;
  int         miscompares = 0;
  int         n_compared = 0;

  initial begin
    forever #4 clk = ~clk;
  end

  pm_partner #(.REF_HALF(8)) pm_u (.clk_sys_i(clk), .pd_req_i(pd_r), .halt_req_i(h_r),
    .ref_off_req_i(off_r), .input_ref_clock_o(ref_clk), .power_down_n_o(pd_n),
    .output_halt_n_o(halt_n));

  clk_out_park #(.N_OUT(NUM_OUTPUTS), .LOCK_CYC(LK)) dut_u (.clk_sys_i(clk),
    .sys_rst_i(rst), .input_ref_clock_i(ref_clk), .power_down_n_i(pd_n),
    .output_halt_n_i(halt_n), .oe_pin_i(oe_pin), .enable_polarity_sel_i(pol),
    .out_enable_i(oen), .stoppable_i(stp), .powerdown_park_sel_i(pd_sel),
    .stop_park_sel_i(st_sel), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_rdata_o(rd), .read_len_o(rl), .clk_out_true_o(t_o), .clk_out_true_oe_o(t_oe),
    .clk_out_comp_o(c_o), .clk_out_comp_oe_o(c_oe), .drive_2x_o(x2),
    .pll_enable_o(pe), .pll_locked_o(pl));

  // ====================================================================
  // Shared tasks
  // ====================================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Reports whether the true leg of one lane changed within n cycles.
  task automatic seen(input int ln, input int n, output logic s);
    logic p;
    p = t_o[ln];
    s = 1'b0;
    repeat (n) begin
      cyc(1);
      if (t_o[ln] !== p) s = 1'b1;
      p = t_o[ln];
    end
  endtask : seen

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    cyc(2);
    chk(rd, e);
  endtask : rd_reg

  task automatic wait_lock;
    int k;
    k = 0;
    while (pl !== 1'b1 && k < LK + 100) begin
      cyc(1);
      k++;
    end
    chk({7'h00, pl}, 8'h01);
  endtask : wait_lock

  // ====================================================================
  // Scenarios
  // ====================================================================
  task automatic t_regs;
    rd_reg(REG_ADDR_READ_LEN, READ_LEN_RESET);
    wr_reg(REG_ADDR_READ_LEN, 8'hA5);
    cyc(1);
    chk(rl, 8'hA5);
    wr_reg(8'h05, 8'h3C);
    rd_reg(8'h05, 8'h00);
    rd_reg(REG_ADDR_READ_LEN, 8'hA5);
    $display("test regs done");
  endtask : t_regs

  task automatic t_run;
    logic s;
    wait_lock();
    @(posedge clk);
    pol <= 1'b1;
    oe_pin <= 4'h4;
    cyc(40);
    chk({4'h0, t_oe[3:2], c_oe[3:2]}, 8'h00);
    seen(0, 40, s);
    chk({7'h00, s}, 8'h01);
    chk({6'h00, c_o[0], c_oe[0]}, {6'h00, ~t_o[0], 1'b1});
    @(posedge clk);
    pol <= 1'b0;
    oe_pin <= 4'hF;
    cyc(40);
    $display("test run done");
  endtask : t_run

  task automatic t_halt(input logic sel);
    logic s;
    @(posedge clk);
    st_sel <= sel;
    h_r <= 1'b1;
    cyc(100);
    chk({6'h00, t_oe[0], c_oe[0]}, sel ? 8'h00 : 8'h02);
    chk({7'h00, t_o[0] | sel}, 8'h01);
    seen(0, 40, s);
    chk({7'h00, s}, 8'h00);
    seen(1, 40, s);
    chk({7'h00, s}, 8'h01);
    @(posedge clk);
    h_r <= 1'b0;
    cyc(8);
    chk({7'h00, t_oe[0]}, 8'h01);
    seen(0, 24, s);
    chk({7'h00, s}, 8'h00);
    seen(0, 64, s);
    chk({7'h00, s}, 8'h01);
    chk({7'h00, t_o[0]}, {7'h00, t_o[2]});
    $display("test halt done");
  endtask : t_halt

  task automatic t_pd(input logic sel);
    @(posedge clk);
    pd_sel <= sel;
    st_sel <= 1'b0;
    h_r <= 1'b1;
    pd_r <= 1'b1;
    cyc(12);
    chk({7'h00, pl}, 8'h01);
    cyc(90);
    chk({5'h00, t_oe[2:0]}, sel ? 8'h00 : 8'h07);
    chk({5'h00, c_oe[2:0]}, 8'h00);
    chk({4'h0, sel ? 3'h7 : t_o[2:0], sel | x2}, 8'h0F);
    chk({7'h00, pe}, 8'h00);
    @(posedge clk);
    off_r <= 1'b1;
    cyc(60);
    @(posedge clk);
    off_r <= 1'b0;
    cyc(40);
    @(posedge clk);
    pd_r <= 1'b0;
    h_r <= 1'b0;
    cyc(60);
    chk({5'h00, t_oe[2:0]}, 8'h07);
    chk({6'h00, x2, pe}, 8'h01);
    wait_lock();
    $display("test power-down done");
  endtask : t_pd

  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_run();
    t_halt(1'b0);
    t_halt(1'b1);
    t_pd(1'b0);
    t_pd(1'b1);
    report_and_stop();
  end

  // The tests need under 3000 cycles; this limit leaves wide room.
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
endmodule : clk_out_park_tb
